// ### hdl/ncs_pkg.sv
// shared types and constants for the course/time sentence generator
package ncs_pkg;
  localparam int unsigned CLK_HZ      = 125_000_000;
  localparam int unsigned BAUD        = 4800;
  localparam int unsigned BIT_CYC     = CLK_HZ / BAUD;
  localparam int unsigned ZDA_LIM_MS  = 500;
  localparam int unsigned ZDA_LIM_CYC = (CLK_HZ / 1000) * ZDA_LIM_MS;
  localparam int unsigned FRAME_BITS  = 10;

  localparam logic [5:0] ZDA_STAR = 6'h22;
  localparam logic [5:0] VTG_STAR = 6'h25;
  localparam logic [5:0] TAIL_LEN = 6'h04;

  localparam logic [7:0] CH_DOL   = 8'h24;
  localparam logic [7:0] CH_COM   = 8'h2c;
  localparam logic [7:0] CH_DOT   = 8'h2e;
  localparam logic [7:0] CH_STAR  = 8'h2a;
  localparam logic [7:0] CH_MINUS = 8'h2d;
  localparam logic [7:0] CH_CR    = 8'h0d;
  localparam logic [7:0] CH_LF    = 8'h0a;
  localparam logic [7:0] CH_0     = 8'h30;
  localparam logic [7:0] CH_HEXA  = 8'h37;
  localparam logic [7:0] CH_A     = 8'h41;
  localparam logic [7:0] CH_D     = 8'h44;
  localparam logic [7:0] CH_G     = 8'h47;
  localparam logic [7:0] CH_K     = 8'h4b;
  localparam logic [7:0] CH_N     = 8'h4e;
  localparam logic [7:0] CH_P     = 8'h50;
  localparam logic [7:0] CH_T     = 8'h54;
  localparam logic [7:0] CH_V     = 8'h56;
  localparam logic [7:0] CH_Z     = 8'h5a;

  // [4] hundreds, [3] tens, [2] units, [1] tenths, [0] hundredths
  typedef logic [4:0][3:0] ncs_dec5_t;

  typedef struct packed {
    logic      valid;
    ncs_dec5_t course;
    ncs_dec5_t knots;
    ncs_dec5_t kmh;
  } ncs_fix_t;

  typedef struct packed {
    logic [1:0][3:0] hh;
    logic [1:0][3:0] mm;
    logic [1:0][3:0] ss;
    logic [1:0][3:0] cc;
    logic [1:0][3:0] day;
    logic [1:0][3:0] mon;
    logic [3:0][3:0] year;
    logic            tz_east;
    logic [1:0][3:0] tzh;
    logic [1:0][3:0] tzm;
  } ncs_time_t;

  typedef enum logic [1:0] {
    S_IDLE = 2'h0,
    S_ZDA  = 2'h1,
    S_VTG  = 2'h3
  } ncs_state_t;
endpackage : ncs_pkg

// ### hdl/ncs_uart_tx.sv
// 8N1 serial transmitter with a registered line output
`timescale 1ns/10ps
`default_nettype none
module ncs_uart_tx
  import ncs_pkg::*;
#(
  parameter int unsigned BIT_CYCLES = BIT_CYC
) (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       start,
  input  wire logic [7:0] data,
  output var  logic       ready,
  output var  logic       txd
);
  logic [9:0]  shf_q, shf_d;
  logic [3:0]  bits_q, bits_d;
  logic [31:0] div_q, div_d;
  logic        rdy_d, txd_d;

  always_comb begin
    shf_d  = shf_q;
    bits_d = bits_q;
    div_d  = div_q;
    if (ready && start) begin
      shf_d  = {1'b1, data, 1'b0};
      bits_d = 4'(FRAME_BITS);
      div_d  = BIT_CYCLES - 1;
    end else if (bits_q != 4'h0) begin
      if (div_q == 32'h0) begin
        shf_d  = {1'b1, shf_q[9:1]};
        bits_d = bits_q - 4'h1;
        div_d  = BIT_CYCLES - 1;
      end else begin
        div_d = div_q - 32'h1;
      end
    end
    rdy_d = (bits_d == 4'h0);
    txd_d = (bits_d == 4'h0) ? 1'b1 : shf_d[0];
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      shf_q  <= 10'h3ff;
      bits_q <= 4'h0;
      div_q  <= 32'h0;
      ready  <= 1'b1;
      txd    <= 1'b1;
    end else begin
      shf_q  <= shf_d;
      bits_q <= bits_d;
      div_q  <= div_d;
      ready  <= rdy_d;
      txd    <= txd_d;
    end
  end
endmodule : ncs_uart_tx
`default_nettype wire

// ### hdl/ncs_gen.sv
// course/speed and time/date sentence generator on one serial line
// How it works
// RULE1: the course sentence opens with true course followed by the T marker.
// RULE2: magnetic course and its unit are left empty, only commas are sent.
// RULE3: speed goes out in knots with N, then in km/h with K.
// RULE4: the last course field is A for autonomous data, N when not valid.
// RULE5: a course sentence each second; only the one after a fresh fix has values, others 0.00; the code sends empty fields if the fix is not valid.
// RULE6: the time sentence for a pulse is finished well inside 500 ms of that pulse.
// RULE7: when not synchronized the time sentence carries only separators and tail.
// RULE8: the time field is hhmmss.ss of the pulse just issued.
// RULE9: after the date comes the zone hour offset, with a minus sign for east.
// RULE10: the last time-sentence field is the zone minute offset, two digits.
// RULE11: each sentence ends in *, two upper-case hex checksum digits, CR and LF.
// RULE12: day and month are two digits, year four digits, after the time field.
`timescale 1ns/10ps
`default_nettype none
module ncs_gen
  import ncs_pkg::*;
#(
  parameter int unsigned BIT_CYCLES  = BIT_CYC,
  parameter int unsigned ZDA_LIM_CYCLES = ZDA_LIM_CYC
) (
  input  wire logic      clk_sys,
  input  wire logic      rst,
  input  wire logic      pps_tick,
  input  wire logic      fix_stb,
  input  wire ncs_fix_t  fix_in,
  input  wire ncs_time_t time_in,
  input  wire logic      synced,
  output var  logic      ser_out,
  output var  logic      busy
);
  function automatic logic [7:0] dig(input logic [3:0] d);
    return CH_0 | {4'h0, d};
  endfunction : dig

  function automatic logic [7:0] hexc(input logic [3:0] n);
    return (n < 4'ha) ? dig(n) : CH_HEXA + {4'h0, n};
  endfunction : hexc

  // {emit, char}; integer part drops leading zeros but keeps the units digit
  function automatic logic [8:0] num_char(input ncs_dec5_t v,
                                          input logic [2:0] k);
    case (k)
      3'h0:    return {v[4] != 4'h0, dig(v[4])};
      3'h1:    return {(v[4] | v[3]) != 4'h0, dig(v[3])};
      3'h2:    return {1'b1, dig(v[2])};
      3'h3:    return {1'b1, CH_DOT};
      3'h4:    return {1'b1, dig(v[1])};
      default: return {1'b1, dig(v[0])};
    endcase
  endfunction : num_char

  ncs_state_t state_q, state_d;
  logic [5:0] step_q, step_d;
  logic [7:0] cks_q, cks_d;
  ncs_fix_t   fix_q, fix_d, vtg_q, vtg_d;
  ncs_time_t  tim_q, tim_d;
  logic       sync_q, sync_d, fresh_q, fresh_d, busy_d;
  logic       emit, tx_go, tx_rdy, take;
  logic [7:0] ch;
  logic [5:0] star;
  logic [8:0] nc;
  logic [5:0] rel;

  assign star = (state_q == S_VTG) ? VTG_STAR : ZDA_STAR;
  assign take = pps_tick && (state_q == S_IDLE);

  // character selection for the current step
  always_comb begin
    emit = 1'b1;
    ch   = CH_COM;
    nc   = 9'h0;
    rel  = 6'h0;
    if (step_q == star) begin
      ch = CH_STAR; // RULE11
    end else if (step_q == star + 6'h1) begin
      ch = hexc(cks_q[7:4]); // RULE11
    end else if (step_q == star + 6'h2) begin
      ch = hexc(cks_q[3:0]); // RULE11
    end else if (step_q == star + 6'h3) begin
      ch = CH_CR; // RULE11
    end else if (step_q == star + TAIL_LEN) begin
      ch = CH_LF; // RULE11
    end else if (state_q == S_VTG) begin
      if (step_q >= 6'h7 && step_q <= 6'hc) begin
        rel = step_q - 6'h7;
        nc  = num_char(vtg_q.course, rel[2:0]); // RULE1
      end else if (step_q >= 6'h12 && step_q <= 6'h17) begin
        rel = step_q - 6'h12;
        nc  = num_char(vtg_q.knots, rel[2:0]); // RULE3
      end else if (step_q >= 6'h1b && step_q <= 6'h20) begin
        rel = step_q - 6'h1b;
        nc  = num_char(vtg_q.kmh, rel[2:0]); // RULE3
      end
      case (step_q)
        6'h00: ch = CH_DOL;
        6'h01: ch = CH_G;
        6'h02: ch = CH_P;
        6'h03: ch = CH_V;
        6'h04: ch = CH_T;
        6'h05: ch = CH_G;
        6'h0e: ch = CH_T; // RULE1
        6'h19: ch = CH_N; // RULE3
        6'h22: ch = CH_K; // RULE3
        6'h24: ch = vtg_q.valid ? CH_A : CH_N; // RULE4
        6'h07, 6'h08, 6'h09, 6'h0a, 6'h0b, 6'h0c,
        6'h12, 6'h13, 6'h14, 6'h15, 6'h16, 6'h17,
        6'h1b, 6'h1c, 6'h1d, 6'h1e, 6'h1f, 6'h20: begin
          emit = nc[8] && vtg_q.valid;
          ch   = nc[7:0];
        end
        default: ch = CH_COM; // RULE2
      endcase
    end else begin
      case (step_q)
        6'h00: ch = CH_DOL;
        6'h01: ch = CH_G;
        6'h02: ch = CH_P;
        6'h03: ch = CH_Z;
        6'h04: ch = CH_D;
        6'h05: ch = CH_A;
        6'h07: ch = dig(tim_q.hh[1]); // RULE8
        6'h08: ch = dig(tim_q.hh[0]);
        6'h09: ch = dig(tim_q.mm[1]);
        6'h0a: ch = dig(tim_q.mm[0]);
        6'h0b: ch = dig(tim_q.ss[1]);
        6'h0c: ch = dig(tim_q.ss[0]);
        6'h0d: ch = CH_DOT; // RULE8
        6'h0e: ch = dig(tim_q.cc[1]);
        6'h0f: ch = dig(tim_q.cc[0]);
        6'h11: ch = dig(tim_q.day[1]); // RULE12
        6'h12: ch = dig(tim_q.day[0]);
        6'h14: ch = dig(tim_q.mon[1]);
        6'h15: ch = dig(tim_q.mon[0]);
        6'h17: ch = dig(tim_q.year[3]);
        6'h18: ch = dig(tim_q.year[2]);
        6'h19: ch = dig(tim_q.year[1]);
        6'h1a: ch = dig(tim_q.year[0]);
        6'h1c: ch = CH_MINUS; // RULE9
        6'h1d: ch = dig(tim_q.tzh[1]); // RULE9
        6'h1e: ch = dig(tim_q.tzh[0]);
        6'h20: ch = dig(tim_q.tzm[1]); // RULE10
        6'h21: ch = dig(tim_q.tzm[0]);
        default: ch = CH_COM;
      endcase
      if (step_q == 6'h1c) begin
        emit = sync_q && tim_q.tz_east; // RULE9
      end else if (ch != CH_COM && step_q > 6'h6) begin
        emit = sync_q; // RULE7
      end
    end
  end

  assign tx_go = (state_q != S_IDLE) && emit && tx_rdy;

  // sequencing, checksum and snapshots
  always_comb begin
    state_d = state_q;
    step_d  = step_q;
    cks_d   = cks_q;
    fix_d   = fix_q;
    vtg_d   = vtg_q;
    tim_d   = tim_q;
    sync_d  = sync_q;
    // a fix landing on the pulse that consumes the old one stays fresh
    fresh_d = fix_stb || (fresh_q && !take); // RULE5
    if (fix_stb) begin
      fix_d = fix_in;
    end
    if (take) begin
      tim_d        = time_in; // RULE8
      sync_d       = synced; // RULE7
      vtg_d        = fix_q;
      vtg_d.course = fresh_q ? fix_q.course : '0; // RULE5
      vtg_d.knots  = fresh_q ? fix_q.knots : '0;
      vtg_d.kmh    = fresh_q ? fix_q.kmh : '0;
      state_d      = S_ZDA; // RULE6
      step_d       = 6'h0;
      cks_d        = 8'h0;
    end else if (state_q != S_IDLE && (tx_go || !emit)) begin
      if (tx_go && step_q != 6'h0 && step_q < star) begin
        cks_d = cks_q ^ ch; // RULE11
      end
      step_d = step_q + 6'h1;
      if (step_q == star + TAIL_LEN) begin
        step_d = 6'h0;
        cks_d  = 8'h0;
        unique case (state_q)
          S_ZDA:   state_d = S_VTG; // RULE5
          S_VTG:   state_d = S_IDLE;
          default: state_d = S_IDLE;
        endcase
      end
    end
    busy_d = (state_d != S_IDLE);
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q <= S_IDLE;
      step_q  <= 6'h0;
      cks_q   <= 8'h0;
      fix_q   <= '0;
      vtg_q   <= '0;
      tim_q   <= '0;
      sync_q  <= 1'b0;
      fresh_q <= 1'b0;
      busy    <= 1'b0;
    end else begin
      state_q <= state_d;
      step_q  <= step_d;
      cks_q   <= cks_d;
      fix_q   <= fix_d;
      vtg_q   <= vtg_d;
      tim_q   <= tim_d;
      sync_q  <= sync_d;
      fresh_q <= fresh_d;
      busy    <= busy_d;
    end
  end

  ncs_uart_tx #(
    .BIT_CYCLES (BIT_CYCLES)
  ) u_tx (
    .clk_sys (clk_sys),
    .rst     (rst),
    .start   (tx_go),
    .data    (ch),
    .ready   (tx_rdy),
    .txd     (ser_out)
  );

  // helper: cycles since the pulse while the time sentence is in flight
  logic [31:0] zda_cnt_q, zda_cnt_d;
  always_comb begin
    zda_cnt_d = zda_cnt_q;
    if (take) begin
      zda_cnt_d = 32'h0;
    end else if (state_q == S_ZDA) begin
      zda_cnt_d = zda_cnt_q + 32'h1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      zda_cnt_q <= 32'h0;
    end else begin
      zda_cnt_q <= zda_cnt_d;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  AST_VTG_TRUE: assert property ( // RULE1
    tx_go && state_q == S_VTG && step_q == 6'h0e |-> ch == CH_T)
    else $error("course marker is not T");
  AST_VTG_MAG_EMPTY: assert property ( // RULE2
    tx_go && state_q == S_VTG && step_q == 6'h0f
      |=> (step_q == 6'h10) && (ch == CH_COM))
    else $error("magnetic fields are not empty");
  AST_VTG_UNITS: assert property ( // RULE3
    tx_go && state_q == S_VTG && (step_q == 6'h19 || step_q == 6'h22)
      |-> ch == ((step_q == 6'h19) ? CH_N : CH_K))
    else $error("speed unit letter wrong");
  AST_VTG_MODE: assert property ( // RULE4
    tx_go && state_q == S_VTG && step_q == 6'h24
      |-> ch == (vtg_q.valid ? CH_A : CH_N))
    else $error("mode letter wrong");
  AST_STALE_ZERO: assert property ( // RULE5
    take && !fresh_q && !fix_stb |=> vtg_q.course == '0 && vtg_q.kmh == '0
      && !fresh_q)
    else $error("stale fix values reported");
  AST_ZDA_DEADLINE: assert property ( // RULE6
    state_q == S_ZDA
      |-> zda_cnt_q + FRAME_BITS * BIT_CYCLES < ZDA_LIM_CYCLES)
    else $error("time sentence too late after pulse");
  AST_ZDA_NULL: assert property ( // RULE7
    tx_go && state_q == S_ZDA && !sync_q && step_q > 6'h6 && step_q < star
      |-> ch == CH_COM)
    else $error("data in unsynchronized time sentence");
  AST_ZDA_POINT: assert property ( // RULE8
    tx_go && state_q == S_ZDA && step_q == 6'h0d |-> sync_q && ch == CH_DOT)
    else $error("time field point misplaced");
  AST_ZDA_EAST: assert property ( // RULE9
    tx_go && state_q == S_ZDA && step_q == 6'h1c |-> tim_q.tz_east)
    else $error("minus sign without east offset");
  AST_TAIL: assert property ( // RULE11
    tx_go && step_q == star + 6'h3 |-> ch == CH_CR ##1 (step_q == star + 6'h4))
    else $error("carriage return not before line feed");
endmodule : ncs_gen
`default_nettype wire

// ### tb/ncs_rx_model.sv
// serial receiver model that collects whole sentences from the line
`timescale 1ns/10ps
`default_nettype none
module ncs_rx_model #(
  parameter int unsigned BIT_CYCLES = 4
) (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic ser_in
);
  string       lines[$];
  string       cur;
  int unsigned n_frame_err;
  logic [7:0]  ch;

  initial begin
    cur = "";
    n_frame_err = 0;
    forever begin
      @(posedge clk_sys);
      if (!rst && ser_in === 1'b0) begin
        // sample mid-bit so a one-cycle skew still lands inside the bit
        repeat (BIT_CYCLES / 2) @(posedge clk_sys);
        for (int i = 0; i < 8; i++) begin
          repeat (BIT_CYCLES) @(posedge clk_sys);
          ch[i] = ser_in;
        end
        repeat (BIT_CYCLES) @(posedge clk_sys);
        if (ser_in !== 1'b1) n_frame_err++;
        cur = $sformatf("%s%c", cur, ch);
        if (ch == 8'h0a) begin
          lines.push_back(cur);
          cur = "";
        end
      end
    end
  end
endmodule : ncs_rx_model
`default_nettype wire

// ### tb/tb_nmea_course_time_sentence_gen.sv
// self-checking bench for the course/time sentence generator
`timescale 1ns/10ps
`default_nettype none
module tb_nmea_course_time_sentence_gen
  import ncs_pkg::*;
;
  localparam int unsigned BC = 4;
  localparam int unsigned ZL = 2000;

  logic        clk_sys;
  logic        rst;
  logic        pps_tick;
  logic        fix_stb;
  ncs_fix_t    fix_in;
  ncs_time_t   time_in;
  logic        synced;
  logic        ser_out;
  logic        busy;
  int unsigned n_mismatch = 0;
  int unsigned n_compared = 0;
  int unsigned cyc = 0;
  int unsigned t_pulse = 0;

  ncs_gen #(.BIT_CYCLES(BC), .ZDA_LIM_CYCLES(ZL)) u_dut (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .pps_tick (pps_tick),
    .fix_stb  (fix_stb),
    .fix_in   (fix_in),
    .time_in  (time_in),
    .synced   (synced),
    .ser_out  (ser_out),
    .busy     (busy)
  );

  ncs_rx_model #(.BIT_CYCLES(BC)) u_rx (
    .clk_sys (clk_sys),
    .rst     (rst),
    .ser_in  (ser_out)
  );

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) cyc <= cyc + 1;

  function automatic byte hexc(logic [3:0] n);
    return (n < 4'ha) ? 8'h30 + n : 8'h37 + n;
  endfunction : hexc

  // expected checksum is worked out here, independent of the design
  function automatic string with_cs(string body);
    logic [7:0] x;
    x = 8'h00;
    for (int i = 1; i < body.len(); i++) x ^= body[i];
    return $sformatf("%s*%c%c", body, hexc(x[7:4]), hexc(x[3:0]));
  endfunction : with_cs

  task automatic check_str(string what, string exp, string got);
    n_compared++;
    if (exp != got) begin
      n_mismatch++;
      $display("mismatch %s expected %s seen %s", what, exp, got);
    end
  endtask : check_str

  task automatic check_bit(string what, logic exp, logic got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask : check_bit

  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim

  // the CR and LF are stripped before printing so messages stay on one line
  task automatic get_line(string what, string exp);
    string s;
    int    n;
    n = 0;
    s = "";
    while (u_rx.lines.size() == 0 && n < 6000) begin
      @(posedge clk_sys);
      n++;
    end
    if (u_rx.lines.size() != 0) s = u_rx.lines.pop_front();
    check_bit("crlf", 1'b1, s.len() > 2 &&
              s.substr(s.len() - 2, s.len() - 1) == "\015\n");
    if (s.len() > 2) s = s.substr(0, s.len() - 3);
    check_str(what, with_cs(exp), s);
  endtask : get_line

  task automatic expect_pair(string zda, string vtg);
    get_line("zda", zda);
    check_bit("zda_in_time", 1'b1, (cyc - t_pulse) <= ZL);
    get_line("vtg", vtg);
  endtask : expect_pair

  task automatic pulse(bit keep);
    @(negedge clk_sys);
    pps_tick = 1'b1;
    if (keep) t_pulse = cyc;
    @(negedge clk_sys);
    pps_tick = 1'b0;
  endtask : pulse

  task automatic send_fix(logic v, ncs_dec5_t c, ncs_dec5_t k, ncs_dec5_t m);
    @(negedge clk_sys);
    fix_in = '{valid: v, course: c, knots: k, kmh: m};
    fix_stb = 1'b1;
    @(negedge clk_sys);
    fix_stb = 1'b0;
  endtask : send_fix

  task automatic set_time(logic [31:0] hms, logic [31:0] dmy, logic e,
                          logic [15:0] tz, logic sy);
    @(negedge clk_sys);
    time_in = '{hh: hms[31:24], mm: hms[23:16], ss: hms[15:8],
                cc: hms[7:0], day: dmy[31:24], mon: dmy[23:16],
                year: {dmy[15:0]}, tz_east: e, tzh: tz[15:8], tzm: tz[7:0]};
    synced = sy;
  endtask : set_time

  task automatic t_unsynced();
    set_time(32'h12000000, 32'h01012000, 1'b1, 16'h0300, 1'b0);
    send_fix(1'b0, '0, '0, '0);
    pulse(1'b1);
    @(negedge clk_sys);
    check_bit("busy", 1'b1, busy);
    expect_pair("$GPZDA,,,,,,", "$GPVTG,,T,,,,N,,K,N");
  endtask : t_unsynced

  task automatic t_fresh();
    set_time(32'h17565800, 32'h20052008, 1'b0, 16'h0700, 1'b1);
    send_fix(1'b1, 20'h15814, 20'h00008, 20'h00014);
    pulse(1'b1);
    repeat (100) @(negedge clk_sys);
    // a pulse while busy must be dropped, not queued
    pulse(1'b0);
    expect_pair("$GPZDA,175658.00,20,05,2008,07,00",
                "$GPVTG,158.14,T,,,0.08,N,0.14,K,A");
    repeat (50) @(negedge clk_sys);
    check_bit("busy", 1'b0, busy);
    check_bit("idle", 1'b1, ser_out);
  endtask : t_fresh

  task automatic t_stale();
    set_time(32'h23595999, 32'h31122079, 1'b1, 16'h0530, 1'b1);
    pulse(1'b1);
    expect_pair("$GPZDA,235959.99,31,12,2079,-05,30",
                "$GPVTG,0.00,T,,,0.00,N,0.00,K,A");
    set_time(32'h00000000, 32'h01011980, 1'b1, 16'h0530, 1'b0);
    pulse(1'b1);
    expect_pair("$GPZDA,,,,,,", "$GPVTG,0.00,T,,,0.00,N,0.00,K,A");
  endtask : t_stale

  task automatic t_digits();
    set_time(32'h09050700, 32'h02031999, 1'b0, 16'h1100, 1'b1);
    send_fix(1'b1, 20'h00050, 20'h01234, 20'h10000);
    pulse(1'b1);
    expect_pair("$GPZDA,090507.00,02,03,1999,11,00",
                "$GPVTG,0.50,T,,,12.34,N,100.00,K,A");
  endtask : t_digits

  // a fix on the very edge that takes a pulse stays fresh for the next one
  task automatic t_same_edge();
    set_time(32'h08300000, 32'h15071985, 1'b0, 16'h0000, 1'b1);
    @(negedge clk_sys);
    fix_in = '{valid: 1'b1, course: 20'h27100, knots: 20'h00250,
               kmh: 20'h00463};
    fix_stb = 1'b1;
    pps_tick = 1'b1;
    t_pulse = cyc;
    @(negedge clk_sys);
    fix_stb = 1'b0;
    pps_tick = 1'b0;
    expect_pair("$GPZDA,083000.00,15,07,1985,00,00",
                "$GPVTG,0.00,T,,,0.00,N,0.00,K,A");
    pulse(1'b1);
    expect_pair("$GPZDA,083000.00,15,07,1985,00,00",
                "$GPVTG,271.00,T,,,2.50,N,4.63,K,A");
  endtask : t_same_edge

  initial begin
    rst = 1'b1;
    pps_tick = 1'b0;
    fix_stb = 1'b0;
    fix_in = '0;
    time_in = '0;
    synced = 1'b0;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 1'b0;
    check_bit("busy", 1'b0, busy);
    check_bit("idle", 1'b1, ser_out);
    t_unsynced();
    t_fresh();
    t_stale();
    t_digits();
    t_same_edge();
    check_bit("framing", 1'b1, u_rx.n_frame_err == 0);
    end_sim();
  end

  // seven sentence pairs take about 19k cycles
  initial begin
    repeat (60000) @(posedge clk_sys);
    n_mismatch++;
    end_sim();
  end
endmodule : tb_nmea_course_time_sentence_gen
`default_nettype wire
